// ===== design/ycf_capture_fifo.sv
// Purpose: programmable-depth fifo buffering yuv words between capture, memory mover and display path
// Assumes: registers and the memory-mover port are on sys_clk_i; mode comes from logic on the same clock
// Notes:   main store in dwords, a halfword pairing stage on the mover write path, 4-dword output stage
//
// Summary of operation
// - The programmed depth is the 8-bit size field plus seven, in 4-byte units.
// - Main storage tops out at 264 bytes (66 dwords), with a 4-dword output stage counted within the set size and a halfword input hold outside it.
// - The 16-bit data port is reachable only by the memory mover at its own address, never as a register.
// - A read-only 16-bit register reports the readable data in 32-bit words.
// - A 2-bit threshold reports fewer than three dwords, three or more dwords, above a quarter, or above half of the set size.
// - Read-only full and empty flags read 1 while their condition holds.
// - A separate read-only field supplies bits 17-16 of the valid-data count.
`timescale 1ns/1ps
`default_nettype none
`include "ycf_defines.svh"
module ycf_capture_fifo #(
	parameter int MAIN_DWORDS = `YCF_MAIN_DWORDS,
	parameter int OUT_DWORDS  = `YCF_OUT_DWORDS
) (
	// clock, reset, enable
	input  wire logic               sys_clk_i,
	input  wire logic               rst_b_i,
	input  wire logic               ce_i,
	// mode select
	input  wire ycf_pkg::ycf_mode_e mode_i,
	// register port
	input  wire logic [15:0]        reg_addr_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	input  wire logic [15:0]        reg_wdata_i,
	output logic      [15:0]        reg_rdata_o,
	// memory mover data port
	input  wire logic [31:0]        dmm_addr_i,
	input  wire logic               dmm_wr_i,
	input  wire logic               dmm_rd_i,
	input  wire ycf_pkg::ycf_half_t dmm_wdata_i,
	output logic                    dmm_ack_o,
	output var ycf_pkg::ycf_half_t  dmm_rdata_o,
	// capture source
	input  wire logic               cap_valid_i,
	output logic                    cap_ready_o,
	input  wire ycf_pkg::ycf_word_t cap_data_i,
	// display sink
	output logic                    disp_valid_o,
	input  wire logic               disp_ready_i,
	output var ycf_pkg::ycf_word_t  disp_data_o
);
	import ycf_pkg::*;

	localparam int PW = $clog2(MAIN_DWORDS);
	localparam int CW = $clog2(MAIN_DWORDS+1);
	localparam int OW = $clog2(OUT_DWORDS+1);

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]  depth_field, next_depth_field;
	logic [15:0] next_reg_rdata;
	logic [8:0]  set_dwords;
	logic [CW-1:0] main_cap;
	ycf_count_t  total;
	logic [1:0]  thr;
	logic        is_full, is_empty;
	logic [CW-1:0] main_cnt;
	logic [OW-1:0] out_cnt;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction : hit

	always_comb begin
		set_dwords = {1'b0, depth_field} + {1'b0, `YCF_DEPTH_BIAS};
		// the bias already covers both stages; clamp keeps the main store within its 264 bytes
		if (set_dwords > 9'(MAIN_DWORDS + OUT_DWORDS))
			main_cap = CW'(MAIN_DWORDS);
		else if (set_dwords > 9'(OUT_DWORDS))
			main_cap = CW'(set_dwords - 9'(OUT_DWORDS));
		else
			main_cap = CW'(1);
		total    = ycf_count_t'(main_cnt) + ycf_count_t'(out_cnt);
		is_empty = (total == '0);
		is_full  = (total >= ycf_count_t'(set_dwords)) || (main_cnt >= main_cap);
		if ((total << 1) > ycf_count_t'(set_dwords))
			thr = 2'b11;
		else if ((total << 2) > ycf_count_t'(set_dwords))
			thr = 2'b10;
		else if (total >= ycf_count_t'(`YCF_THR_MIN_DWORDS))
			thr = 2'b01;
		else
			thr = 2'b00;
	end

	always_comb begin
		next_depth_field = depth_field;
		if (ce_i && reg_wr_i && hit(reg_addr_i, `YCF_REG_DEPTH))
			next_depth_field = reg_wdata_i[7:0];
		next_reg_rdata = reg_rdata_o;
		if (ce_i && reg_rd_i) begin
			// the data port is deliberately absent here; unmapped offsets read zero
			if (hit(reg_addr_i, `YCF_REG_STATUS))
				next_reg_rdata = {`YCF_STATUS_RSVD, thr, is_full, is_empty};
			else if (hit(reg_addr_i, `YCF_REG_DEPTH))
				next_reg_rdata = {8'h00, depth_field};
			else if (hit(reg_addr_i, `YCF_REG_VALID_COUNT))
				next_reg_rdata = total[15:0];
			else if (hit(reg_addr_i, `YCF_REG_COUNT_EXT))
				next_reg_rdata = 16'(total[17:16]) << `YCF_EXT_LSB;
			else
				next_reg_rdata = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			depth_field <= `YCF_DEPTH_RESET;
			reg_rdata_o <= 16'h0000;
		end else begin
			depth_field <= next_depth_field;
			reg_rdata_o <= next_reg_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// memory mover port and halfword pairing
	logic      dmm_sel, dmm_rd_ack, dmm_wr_ack, main_wr_ok;
	logic      rd_half, next_rd_half, wr_half, next_wr_half;
	ycf_half_t low_hold, next_low_hold, next_dmm_rdata;
	logic      out_valid, out_pop;
	ycf_word_t out_data;

	assign dmm_sel    = (dmm_addr_i == `YCF_DMA_DATA_ADDR);
	assign main_wr_ok = (main_cnt < main_cap);
	assign dmm_rd_ack = ce_i && dmm_sel && dmm_rd_i && (mode_i == YCF_CAPTURE) && out_valid;
	// the low half only lands in the input stage, so it never waits on the main store
	assign dmm_wr_ack = ce_i && dmm_sel && dmm_wr_i && (mode_i == YCF_DISPLAY) && (!wr_half || main_wr_ok);
	assign dmm_ack_o  = dmm_rd_ack || dmm_wr_ack;
	assign out_pop    = (mode_i == YCF_CAPTURE) ? (dmm_rd_ack && rd_half) : disp_ready_i;

	always_comb begin
		next_rd_half   = dmm_rd_ack ? !rd_half : rd_half;
		next_dmm_rdata = dmm_rd_ack ? (rd_half ? out_data[31:16] : out_data[15:0]) : dmm_rdata_o;
		next_wr_half   = dmm_wr_ack ? !wr_half : wr_half;
		next_low_hold  = (dmm_wr_ack && !wr_half) ? dmm_wdata_i : low_hold;
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_half     <= 1'b0;
			wr_half     <= 1'b0;
			low_hold    <= 16'h0000;
			dmm_rdata_o <= 16'h0000;
		end else begin
			rd_half     <= next_rd_half;
			wr_half     <= next_wr_half;
			low_hold    <= next_low_hold;
			dmm_rdata_o <= next_dmm_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// main store
	ycf_word_t     mem [MAIN_DWORDS];
	ycf_word_t     push_data;
	logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [CW-1:0] next_main_cnt;
	logic          push, pop, out_ready;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(MAIN_DWORDS-1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign cap_ready_o = (mode_i == YCF_CAPTURE) && main_wr_ok;

	always_comb begin
		if (mode_i == YCF_CAPTURE) begin
			push      = ce_i && cap_valid_i && cap_ready_o;
			push_data = cap_data_i;
		end else begin
			push      = dmm_wr_ack && wr_half;
			push_data = {dmm_wdata_i, low_hold};
		end
		pop           = ce_i && (main_cnt != '0) && out_ready;
		next_wr_ptr   = push ? bump(wr_ptr) : wr_ptr;
		next_rd_ptr   = pop ? bump(rd_ptr) : rd_ptr;
		next_main_cnt = main_cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			main_cnt <= '0;
		end else begin
			wr_ptr   <= next_wr_ptr;
			rd_ptr   <= next_rd_ptr;
			main_cnt <= next_main_cnt;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= push_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output stage
	ycf_stage_fifo #(
		.WIDTH (32),
		.DEPTH (OUT_DWORDS)
	) u_out_stage (
		.sys_clk_i   (sys_clk_i),
		.rst_b_i     (rst_b_i),
		.ce_i        (ce_i),
		.in_valid_i  (main_cnt != '0),
		.in_ready_o  (out_ready),
		.in_data_i   (mem[rd_ptr]),
		.out_valid_o (out_valid),
		.out_ready_i (out_pop),
		.out_data_o  (out_data),
		.count_o     (out_cnt)
	);

	assign disp_valid_o = (mode_i == YCF_DISPLAY) && out_valid;
	assign disp_data_o  = out_data;
endmodule : ycf_capture_fifo
`default_nettype wire

// ===== design/ycf_defines.svh
// Purpose: offsets, field positions, reset values and sizes of the capture fifo
// Assumes: 16-bit register space, byte offsets as printed
// Notes:   definitions only
`ifndef YCF_DEFINES_SVH
`define YCF_DEFINES_SVH

`define YCF_REG_STATUS       16'h2822
`define YCF_REG_DEPTH        16'h2824
`define YCF_REG_VALID_COUNT  16'h2828
`define YCF_REG_COUNT_EXT    16'h282e
`define YCF_DMA_DATA_ADDR    32'h3000_0000

`define YCF_DEPTH_RESET      8'h3f
`define YCF_DEPTH_BIAS       8'd7
`define YCF_STATUS_RSVD      12'h800
`define YCF_EXT_LSB          8
`define YCF_MAIN_DWORDS      66
`define YCF_OUT_DWORDS       4
`define YCF_THR_MIN_DWORDS   3

`endif

// ===== design/ycf_pkg.sv
// Purpose: shared types of the capture fifo
// Assumes: nothing
// Notes:   constants live in ycf_defines.svh
package ycf_pkg;
	typedef logic [15:0] ycf_half_t;
	typedef logic [31:0] ycf_word_t;
	typedef logic [17:0] ycf_count_t;
	typedef enum logic {
		YCF_DISPLAY = 1'b0,
		YCF_CAPTURE = 1'b1
	} ycf_mode_e;
endpackage : ycf_pkg

// ===== design/ycf_stage_fifo.sv
// Purpose: small flip-flop fifo used as the output stage
// Assumes: one clock, clock enable freezes state
// Notes:   no bypass, so a word pushed is visible the next cycle
`timescale 1ns/1ps
`default_nettype none
module ycf_stage_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_b_i,
	input  wire logic                       ce_i,
	// fill side
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [WIDTH-1:0]           in_data_i,
	// drain side
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic      [WIDTH-1:0]           out_data_o,
	// fill level
	output logic      [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [CW-1:0]    cnt, next_cnt;
	logic             push, pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign in_ready_o  = (cnt != CW'(DEPTH));
	assign out_valid_o = (cnt != '0);
	assign out_data_o  = mem[rd_ptr];
	assign count_o     = cnt;

	always_comb begin
		push        = ce_i && in_valid_i && in_ready_o;
		pop         = ce_i && out_valid_o && out_ready_i;
		next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
		next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
		next_cnt    = cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt    <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			cnt    <= next_cnt;
		end
	end

	// data storage carries no reset
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule : ycf_stage_fifo
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: self-checking bench of the capture fifo
// Assumes: mover model on the data port
// Notes:   expected words queue up, monitors pop them
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ycf_pkg::*;
	logic        sys_clk_i = 0, rst_b_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, rd_q = 0;
	logic        cap_valid_i = 0, disp_ready_i = 0, rd_en = 0, wr_en = 0;
	logic        dmm_wr_i, dmm_rd_i, dmm_ack_o, cap_ready_o, disp_valid_o, wr_next, got;
	ycf_mode_e   mode_i = YCF_CAPTURE;
	logic [15:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, dmm_wdata_i, dmm_rdata_o;
	logic [31:0] dmm_addr_i, got_w, wr_w, v, cap_data_i = 0, disp_data_o, rq[$], cq[$], dq[$];
	logic [7:0]  sz[2] = '{8'h00, 8'h3f};
	int          n_fail = 0, n_tests = 0, s;
	always #5 sys_clk_i = ~sys_clk_i;
	ycf_capture_fifo u_ycf_capture_fifo (.sys_clk_i, .rst_b_i, .ce_i, .mode_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
		.reg_wdata_i, .reg_rdata_o, .dmm_addr_i, .dmm_wr_i, .dmm_rd_i, .dmm_wdata_i, .dmm_ack_o, .dmm_rdata_o,
		.cap_valid_i, .cap_ready_o, .cap_data_i, .disp_valid_o, .disp_ready_i, .disp_data_o);
	ycf_mover_model u_ycf_mover_model (.sys_clk_i, .rst_b_i, .rd_en_i(rd_en), .wr_en_i(wr_en), .wr_next_o(wr_next),
		.wr_dword_o(wr_w), .got_o(got), .got_dword_o(got_w), .dmm_ack_i(dmm_ack_o), .dmm_rdata_i(dmm_rdata_o),
		.dmm_addr_o(dmm_addr_i), .dmm_rd_o(dmm_rd_i), .dmm_wr_o(dmm_wr_i), .dmm_wdata_o(dmm_wdata_i));
	////////////////////////////////
	task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
		n_tests++;
		if (got_v !== exp_v) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got_v, exp_v);
		end
	endtask : check
	task automatic report_and_stop;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task automatic reg_op(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= w;
		reg_rd_i <= !w;
		if (!w)
			rq.push_back({16'h0, d});
		@(posedge sys_clk_i);
		reg_wr_i <= 0;
		reg_rd_i <= 0;
	endtask : reg_op
	// status word for t dwords held at a depth of s dwords
	function automatic logic [15:0] stat(input int t);
		return {12'h800, (2 * t > s) ? 2'b11 : (4 * t > s) ? 2'b10 : (t > 2) ? 2'b01 : 2'b00, t >= s, t == 0};
	endfunction : stat
	////////////////////////////////
	always @(posedge sys_clk_i) begin
		if (rd_q)
			check({16'h0, reg_rdata_o}, rq.pop_front());
		rd_q <= reg_rd_i && ce_i;
		if (got)
			check(got_w, cq.pop_front());
		if (wr_next)
			dq.push_back(wr_w);
		if (disp_valid_o && disp_ready_i && ce_i)
			check(disp_data_o, dq.pop_front());
	end
	initial begin
		#300000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h70b5));
		repeat (10) @(posedge sys_clk_i);
		rst_b_i <= 1;
		reg_op(1, 16'h2828, 16'hffff);
		reg_op(0, 16'h2828, 16'h0000);
		reg_op(0, 16'h2826, 16'h0000);
		reg_op(0, 16'h282e, 16'h0000);
		reg_op(0, 16'h2822, 16'h8001);
		reg_op(0, 16'h2824, 16'h003f);
		foreach (sz[i]) begin
			s = sz[i] + 7;
			reg_op(1, 16'h2824, {8'hff, sz[i]});
			reg_op(0, 16'h2824, {8'h00, sz[i]});
			for (int t = 1; t <= s + 1; t++) begin
				v = $urandom;
				@(posedge sys_clk_i);
				cap_valid_i <= 1;
				cap_data_i <= v;
				@(posedge sys_clk_i);
				cap_valid_i <= 0;
				check({31'h0, cap_ready_o}, {31'h0, t <= s});
				if (cap_ready_o)
					cq.push_back(v);
				repeat (3) @(posedge sys_clk_i);
				reg_op(0, 16'h2828, 16'((t > s) ? s : t));
				reg_op(0, 16'h2822, stat((t > s) ? s : t));
			end
			rd_en <= 1;
			for (int k = 0; k < 600 && cq.size() > 0; k++)
				@(posedge sys_clk_i);
			rd_en <= 0;
			check(32'(cq.size()), 0);
			reg_op(0, 16'h2822, stat(0));
		end
		// slow sink so the writer runs into a full fifo
		mode_i <= YCF_DISPLAY;
		wr_en <= 1;
		repeat (600) begin
			@(posedge sys_clk_i);
			ce_i <= $urandom_range(7) != 0;
			disp_ready_i <= $urandom_range(7) == 0;
		end
		ce_i <= 1;
		disp_ready_i <= 0;
		// sink stopped first, so the writer tops the fifo up before it is told to stop
		repeat (400) @(posedge sys_clk_i);
		wr_en <= 0;
		reg_op(0, 16'h2828, 16'(s));
		reg_op(0, 16'h2822, stat(s));
		disp_ready_i <= 1;
		for (int k = 0; k < 300 && dq.size() > 0; k++)
			@(posedge sys_clk_i);
		check(32'(dq.size()), 0);
		repeat (3) @(posedge sys_clk_i);
		reg_op(0, 16'h2822, stat(0));
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire

// ===== testbench/ycf_capture_fifo_asserts.sv
// Purpose: port checks of the capture fifo
// Assumes: one clock, async active-low reset
// Notes:   bound into every ycf_capture_fifo
`timescale 1ns/1ps
`default_nettype none
module ycf_capture_fifo_asserts (
	// clock and control
	input wire logic               sys_clk_i,
	input wire logic               rst_b_i,
	input wire logic               ce_i,
	input wire ycf_pkg::ycf_mode_e mode_i,
	// registers
	input wire logic [15:0]        reg_addr_i,
	input wire logic               reg_rd_i,
	input wire logic [15:0]        reg_rdata_o,
	// mover, capture and display
	input wire logic [31:0]        dmm_addr_i,
	input wire logic               dmm_rd_i,
	input wire logic               dmm_wr_i,
	input wire logic               dmm_ack_o,
	input wire ycf_pkg::ycf_half_t dmm_rdata_o,
	input wire logic               cap_ready_o,
	input wire logic               disp_valid_o
);
	import ycf_pkg::*;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////
	chk_ack_addr: assert property (dmm_ack_o |-> ce_i && dmm_addr_i == 32'h3000_0000)
		else $error("ack off port");
	chk_read_mode: assert property (dmm_ack_o && dmm_rd_i |-> mode_i == YCF_CAPTURE)
		else $error("read ack in display");
	chk_write_mode: assert property (dmm_ack_o && dmm_wr_i |-> mode_i == YCF_DISPLAY)
		else $error("write ack in capture");
	chk_cap_gate: assert property (cap_ready_o |-> mode_i == YCF_CAPTURE)
		else $error("capture ready in display");
	chk_disp_gate: assert property (disp_valid_o |-> mode_i == YCF_DISPLAY)
		else $error("display valid in capture");
	chk_rdata_hold: assert property ($changed(dmm_rdata_o) |-> $past(dmm_ack_o && dmm_rd_i))
		else $error("port data moved");
	chk_reg_hold: assert property ($changed(reg_rdata_o) |-> $past(reg_rd_i && ce_i))
		else $error("read data moved");
	// "low" is never a full dword, so upper byte of size must read zero
	chk_size_field: assert property (reg_rd_i && ce_i && reg_addr_i == 16'h2824 |=> reg_rdata_o[15:8] == 8'h00)
		else $error("size upper byte");
	chk_status_word: assert property (reg_rd_i && ce_i && reg_addr_i == 16'h2822 |=> reg_rdata_o[15:4] == 12'h800
		&& !(reg_rdata_o[1] && reg_rdata_o[0]) && (!reg_rdata_o[0] || reg_rdata_o[3:2] == 2'b00))
		else $error("status word");
	chk_count_ext: assert property (reg_rd_i && ce_i && reg_addr_i == 16'h282e |=> reg_rdata_o[15:10] == 6'h00
		&& reg_rdata_o[7:0] == 8'h00)
		else $error("count extension");
endmodule : ycf_capture_fifo_asserts
bind ycf_capture_fifo ycf_capture_fifo_asserts u_chk (.sys_clk_i, .rst_b_i, .ce_i, .mode_i, .reg_addr_i, .reg_rd_i,
	.reg_rdata_o, .dmm_addr_i, .dmm_rd_i, .dmm_wr_i, .dmm_ack_o, .dmm_rdata_o, .cap_ready_o, .disp_valid_o);
`default_nettype wire

// ===== testbench/ycf_mover_model.sv
// Purpose: memory mover on the fifo data port
// Assumes: requests to the data port address held until acked or until both enables drop
// Notes:   random gaps make it slow at times
`timescale 1ns/1ps
`default_nettype none
module ycf_mover_model (
	// bench side
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        rd_en_i,
	input  wire logic        wr_en_i,
	output logic             wr_next_o,
	output logic      [31:0] wr_dword_o,
	output logic             got_o,
	output logic      [31:0] got_dword_o,
	// data port
	input  wire logic        dmm_ack_i,
	input  wire logic [15:0] dmm_rdata_i,
	output logic      [31:0] dmm_addr_o,
	output logic             dmm_rd_o,
	output logic             dmm_wr_o,
	output logic      [15:0] dmm_wdata_o
);
	logic        half;
	logic        pend;
	logic        go;
	logic [15:0] lo;
	logic [31:0] nv;
	assign wr_next_o = dmm_ack_i && dmm_wr_o && half;
	////////////////////////////////
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			half <= 0;
			pend <= 0;
			got_o <= 0;
			dmm_rd_o <= 0;
			dmm_wr_o <= 0;
			dmm_addr_o <= '1;
			dmm_wdata_o <= '0;
			wr_dword_o <= '0;
		end else begin
			// read data lands one cycle after its ack, low half first
			got_o <= pend && !half;
			pend <= dmm_ack_i && dmm_rd_o;
			if (pend && half)
				lo <= dmm_rdata_i;
			if (pend && !half)
				got_dword_o <= {dmm_rdata_i, lo};
			if (dmm_ack_i)
				half <= !half;
			// a request to a foreign address is answered elsewhere, so it is retired after one cycle
			if (dmm_ack_i || !(dmm_rd_o || dmm_wr_o) || !(rd_en_i || wr_en_i) || dmm_addr_o != 32'h3000_0000) begin
				go = (rd_en_i || wr_en_i) && $urandom_range(3) != 0;
				nv = (dmm_ack_i ^ half) ? wr_dword_o : $urandom;
				dmm_rd_o <= go && rd_en_i;
				dmm_wr_o <= go && wr_en_i;
				// now and then a request goes one word off the port, which must never be taken
				dmm_addr_o <= (go && $urandom_range(7) != 0) ? 32'h3000_0000 : 32'h3000_0004;
				wr_dword_o <= nv;
				dmm_wdata_o <= (dmm_ack_i ^ half) ? nv[31:16] : nv[15:0];
			end
		end
	end
endmodule : ycf_mover_model
`default_nettype wire
